// File: dramel_consts.svh
// Purpose: offsets, fields, reset values and timing counts of the error log and timing block
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes: included by the refresh and top design files and by the bench
`ifndef DRAMEL_CONSTS_SVH
`define DRAMEL_CONSTS_SVH
`define DRAMEL_OFF_FAIL_ADDR 8'hA8
`define DRAMEL_OFF_TIMING 8'hAC
`define DRAMEL_OFF_STATUS 8'hB0
`define DRAMEL_OFF_MASK 8'hB4
`define DRAMEL_TIMING_RESET 32'h30DF3516
`define DRAMEL_REFC_HI 30
`define DRAMEL_REFC_LO 20
`define DRAMEL_STAG_HI 19
`define DRAMEL_STAG_LO 17
`define DRAMEL_REFEN_BIT 16
`define DRAMEL_TIMING_WMASK 32'h7FFFFFFF
`define DRAMEL_ROWS 4
`define DRAMEL_ST_ERR 0
`define DRAMEL_ST_OVF 1
`define DRAMEL_ST_REF 2
`define DRAMEL_ST_BITS 3
`define DRAMEL_REFRESH_PULSE_NS 60
`define DRAMEL_CLK_NS 20
`define DRAMEL_REFRESH_CYC ((`DRAMEL_REFRESH_PULSE_NS + `DRAMEL_CLK_NS - 1) / `DRAMEL_CLK_NS)
`endif

// File: dramel_pkg.sv
// Purpose: types of the error log and timing block
// Assumes: nothing
// Notes: constants live in the header
package dramel_pkg;
  typedef enum logic [1:0] {
    DRAMEL_R_IDLE = 2'b00,
    DRAMEL_R_DATA = 2'b01
  } dramel_rd_t;
  typedef enum logic [1:0] {
    DRAMEL_W_IDLE = 2'b00,
    DRAMEL_W_RESP = 2'b01
  } dramel_wr_t;
endpackage

// File: dramel_timing_if.sv
// Purpose: carries timing settings to the refresh sequencer
// Assumes: single clock
// Notes: ctl side owns fields, seq side owns strobes
`timescale 1ns/1ps
interface dramel_timing_if;
  logic [10:0] refresh_interval_count;
  logic [2:0] refresh_row_stagger;
  logic refresh_enable;
  logic [3:0] ras_n;
  logic refresh_start;
  modport ctl (output refresh_interval_count, output refresh_row_stagger,
    output refresh_enable, input ras_n, input refresh_start);
  modport seq (input refresh_interval_count, input refresh_row_stagger,
    input refresh_enable, output ras_n, output refresh_start);
endinterface

// File: dramel_refresh.sv
// Purpose: refresh interval counter and staggered row strobes
// Assumes: settings stable while refreshing
// Notes: strobes are decoded from counter flops on aclk
`timescale 1ns/1ps
`include "dramel_consts.svh"
module dramel_refresh (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings and strobes
  dramel_timing_if.seq tif
);
  localparam int PW = `DRAMEL_REFRESH_CYC;
  logic [10:0] int_q;
  logic [2:0] stag_q;
  logic [1:0] row_q;
  logic busy_q;
  logic [7:0] pw_q [`DRAMEL_ROWS];
  logic start_q;
  logic tick;

  assign tick = tif.refresh_enable && (int_q >= tif.refresh_interval_count - 11'h001);

  // interval counter, one clock time base
  always_ff @(posedge aclk) begin
    if (!aresetn || !tif.refresh_enable || tick) begin
      int_q <= 11'h000;
    end else begin
      int_q <= int_q + 11'h001;
    end
  end

  // stagger walk over rows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      row_q <= 2'h0;
      stag_q <= 3'h0;
    end else if (tick && !busy_q) begin
      busy_q <= (tif.refresh_row_stagger != 3'h0);
      row_q <= 2'h1;
      stag_q <= 3'h1;
    end else if (busy_q) begin
      if (stag_q >= tif.refresh_row_stagger) begin
        stag_q <= 3'h1;
        row_q <= row_q + 2'h1;
        if (row_q == 2'h3) begin
          busy_q <= 1'b0;
        end
      end else begin
        stag_q <= stag_q + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= tick && !busy_q;
    end
  end
  assign tif.refresh_start = start_q;

  // per row strobe, whole clock widths
  for (genvar r = 0; r < `DRAMEL_ROWS; r++) begin : g_row
    logic go;
    assign go = (tick && !busy_q && (r == 0 || tif.refresh_row_stagger == 3'h0))
      || (busy_q && stag_q >= tif.refresh_row_stagger && row_q == 2'(r));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pw_q[r] <= 8'h00;
      end else if (go) begin
        pw_q[r] <= 8'(PW);
      end else if (pw_q[r] != 8'h00) begin
        pw_q[r] <= pw_q[r] - 8'h01;
      end
    end
    assign tif.ras_n[r] = (pw_q[r] == 8'h00);
  end

  property p_refresh_zero_stagger;
    @(posedge aclk) disable iff (!aresetn)
    (tick && !busy_q && tif.refresh_row_stagger == 3'h0) |=> (tif.ras_n == 4'h0);
  endproperty
  a_refresh_zero_stagger: assert property (p_refresh_zero_stagger) else $error("rows not together");

  property p_no_refresh_disabled;
    @(posedge aclk) disable iff (!aresetn)
    !tif.refresh_enable |=> (!tif.refresh_start && int_q == 11'h000);
  endproperty
  a_no_refresh_disabled: assert property (p_no_refresh_disabled) else $error("refresh while off");
endmodule

// File: dramel_top.sv
// Purpose: ecc fail address log and DRAM timing setup with AXI4-Lite access
// Assumes: ecc and transfer inputs synchronous to aclk
// Notes: one read in flight at most; a second write is accepted while a write response waits
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "dramel_consts.svh"
module dramel_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory transfer tracking
  input wire logic xfer_start,
  input wire logic xfer_qword,
  input wire logic [31:3] xfer_eff_addr,
  // ecc checker
  input wire logic ecc_uncorrectable,
  // dram side
  output logic [3:0] dram_ras_n,
  // interrupt
  output logic irq
);
  dramel_timing_if tif ();
  dramel_pkg::dramel_rd_t rd_q;
  dramel_pkg::dramel_wr_t wr_q;
  logic [31:0] timing_q;
  logic [31:3] fail_addr_q;
  logic [1:0] fail_qw_q;
  logic [1:0] qw_cnt_q;
  logic [`DRAMEL_ST_BITS-1:0] status_q;
  logic [`DRAMEL_ST_BITS-1:0] mask_q;
  logic [7:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic w_have_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [1:0] bresp_q;
  logic [1:0] cur_qw;
  logic wr_go;
  logic [`DRAMEL_ST_BITS-1:0] ev;
  logic [`DRAMEL_ST_BITS-1:0] clr;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `DRAMEL_OFF_FAIL_ADDR) || (a == `DRAMEL_OFF_TIMING)
      || (a == `DRAMEL_OFF_STATUS) || (a == `DRAMEL_OFF_MASK);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
    input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[i*8 +: 8] = n[i*8 +: 8];
      end
    end
  endfunction

  // quadword index in transfer order
  assign cur_qw = xfer_start ? 2'h0 : qw_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || xfer_qword) begin
      qw_cnt_q <= 2'h0;
    end else if (xfer_start) begin
      qw_cnt_q <= 2'h1;
    end else if (qw_cnt_q != 2'h0) begin
      qw_cnt_q <= qw_cnt_q + 2'h1;
    end
  end

  // first failure capture, held until the flag clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_addr_q <= 29'h0;
      fail_qw_q <= 2'h0;
    end else if (ecc_uncorrectable && (!status_q[`DRAMEL_ST_ERR] || clr[`DRAMEL_ST_ERR])) begin
      fail_addr_q <= xfer_eff_addr;
      fail_qw_q <= xfer_qword ? 2'h0 : cur_qw;
    end
  end

  // sticky events
  assign ev[`DRAMEL_ST_ERR] = ecc_uncorrectable;
  assign ev[`DRAMEL_ST_OVF] = ecc_uncorrectable && status_q[`DRAMEL_ST_ERR] &&
    !clr[`DRAMEL_ST_ERR];
  assign ev[`DRAMEL_ST_REF] = tif.refresh_start;
  assign wr_go = aw_have_q && w_have_q && wr_q == dramel_pkg::DRAMEL_W_IDLE;
  assign clr = (wr_go && aw_q == `DRAMEL_OFF_STATUS && ws_q[0]) ?
    w_q[`DRAMEL_ST_BITS-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
    end
  end
  assign irq = |(status_q & mask_q);

  // write channel capture
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_q <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_q <= 32'h0;
      ws_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_q <= s_axi_wdata;
      ws_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing_q <= `DRAMEL_TIMING_RESET;
    end else if (wr_go && aw_q == `DRAMEL_OFF_TIMING) begin
      timing_q <= merge(timing_q, w_q, ws_q) & `DRAMEL_TIMING_WMASK;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= '0;
    end else if (wr_go && aw_q == `DRAMEL_OFF_MASK && ws_q[0]) begin
      mask_q <= w_q[`DRAMEL_ST_BITS-1:0];
    end
  end

  // write response, fail address ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= dramel_pkg::DRAMEL_W_IDLE;
      bresp_q <= 2'b00;
    end else begin
      case (wr_q)
        dramel_pkg::DRAMEL_W_IDLE: begin
          if (wr_go) begin
            wr_q <= dramel_pkg::DRAMEL_W_RESP;
            bresp_q <= mapped(aw_q) ? 2'b00 : 2'b10;
          end
        end
        dramel_pkg::DRAMEL_W_RESP: begin
          if (s_axi_bready) begin
            wr_q <= dramel_pkg::DRAMEL_W_IDLE;
          end
        end
        default: wr_q <= dramel_pkg::DRAMEL_W_IDLE;
      endcase
    end
  end
  assign s_axi_bvalid = (wr_q == dramel_pkg::DRAMEL_W_RESP);
  assign s_axi_bresp = bresp_q;

  // read path
  assign s_axi_arready = (rd_q == dramel_pkg::DRAMEL_R_IDLE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= dramel_pkg::DRAMEL_R_IDLE;
      rdata_q <= 32'h0;
      rresp_q <= 2'b00;
    end else begin
      case (rd_q)
        dramel_pkg::DRAMEL_R_IDLE: begin
          if (s_axi_arvalid) begin
            rd_q <= dramel_pkg::DRAMEL_R_DATA;
            rresp_q <= mapped({s_axi_araddr[7:2], 2'b00}) ? 2'b00 : 2'b10;
            case ({s_axi_araddr[7:2], 2'b00})
              `DRAMEL_OFF_FAIL_ADDR: rdata_q <= {fail_addr_q, fail_qw_q, 1'b0};
              `DRAMEL_OFF_TIMING: rdata_q <= timing_q;
              `DRAMEL_OFF_STATUS: rdata_q <= 32'(status_q);
              `DRAMEL_OFF_MASK: rdata_q <= 32'(mask_q);
              default: rdata_q <= 32'h0;
            endcase
          end
        end
        dramel_pkg::DRAMEL_R_DATA: begin
          if (s_axi_rready) begin
            rd_q <= dramel_pkg::DRAMEL_R_IDLE;
          end
        end
        default: rd_q <= dramel_pkg::DRAMEL_R_IDLE;
      endcase
    end
  end
  assign s_axi_rvalid = (rd_q == dramel_pkg::DRAMEL_R_DATA);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // settings to refresh sequencer
  assign tif.refresh_interval_count = timing_q[`DRAMEL_REFC_HI:`DRAMEL_REFC_LO];
  assign tif.refresh_row_stagger = timing_q[`DRAMEL_STAG_HI:`DRAMEL_STAG_LO];
  assign tif.refresh_enable = timing_q[`DRAMEL_REFEN_BIT] &&
    (timing_q[`DRAMEL_REFC_HI:`DRAMEL_REFC_LO] != 11'h000);
  assign dram_ras_n = tif.ras_n;

  dramel_refresh u_refresh (
    .aclk(aclk),
    .aresetn(aresetn),
    .tif(tif)
  );

  property p_first_kept;
    @(posedge aclk) disable iff (!aresetn)
    (status_q[`DRAMEL_ST_ERR] && !clr[`DRAMEL_ST_ERR]) |=> $stable(fail_addr_q);
  endproperty
  a_first_kept: assert property (p_first_kept) else $error("fail address overwritten");

  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
    (ecc_uncorrectable && !status_q[`DRAMEL_ST_ERR]) |=>
      (fail_addr_q == $past(xfer_eff_addr) && status_q[`DRAMEL_ST_ERR]);
  endproperty
  a_capture: assert property (p_capture) else $error("fail address not captured");

  property p_single_qw;
    @(posedge aclk) disable iff (!aresetn)
    (ecc_uncorrectable && xfer_qword && !status_q[`DRAMEL_ST_ERR]) |=> fail_qw_q == 2'h0;
  endproperty
  a_single_qw: assert property (p_single_qw) else $error("single quadword index not zero");

  property p_qw_order;
    @(posedge aclk) disable iff (!aresetn)
    (xfer_start && !xfer_qword) |=> qw_cnt_q == 2'h1 ##1 qw_cnt_q == 2'h2 ##1 qw_cnt_q == 2'h3;
  endproperty
  a_qw_order: assert property (p_qw_order) else $error("quadword order wrong");

  property p_bit0_zero;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && $past(s_axi_araddr[7:2]) == 6'h2A && $rose(s_axi_rvalid)) |->
      (s_axi_rdata[0] == 1'b0);
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) else $error("reserved bit set");

  property p_reset_timing;
    @(posedge aclk) $rose(aresetn) |-> timing_q == `DRAMEL_TIMING_RESET;
  endproperty
  a_reset_timing: assert property (p_reset_timing) else $error("timing reset value");

  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
    ecc_uncorrectable |=> status_q[`DRAMEL_ST_ERR];
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag not set");

  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

  property p_rdata_hold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata));
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  property p_irq_error;
    @(posedge aclk) disable iff (!aresetn)
    (ecc_uncorrectable && mask_q[`DRAMEL_ST_ERR]) |=> irq;
  endproperty
  a_irq_error: assert property (p_irq_error) else $error("error interrupt missing");

  property p_ro_write;
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && aw_q == `DRAMEL_OFF_FAIL_ADDR && !ecc_uncorrectable) |=>
      ($stable(fail_addr_q) && $stable(fail_qw_q));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("fail address written");

  property p_bit31_zero;
    @(posedge aclk) disable iff (!aresetn)
    timing_q[31] == 1'b0;
  endproperty
  a_bit31_zero: assert property (p_bit31_zero) else $error("timing bit 31 set");

  property p_timing_write;
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && aw_q == `DRAMEL_OFF_TIMING && ws_q == 4'hF) |=>
      (timing_q == ($past(w_q) & `DRAMEL_TIMING_WMASK));
  endproperty
  a_timing_write: assert property (p_timing_write) else $error("timing write lost");

  property p_reset_idle;
    @(posedge aclk)
    !aresetn |=> (!s_axi_bvalid && !s_axi_rvalid && !irq && dram_ras_n == 4'hF);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");

  property p_overflow;
    @(posedge aclk) disable iff (!aresetn)
    (ecc_uncorrectable && status_q[`DRAMEL_ST_ERR] && !clr[`DRAMEL_ST_ERR]) |=>
      status_q[`DRAMEL_ST_OVF];
  endproperty
  a_overflow: assert property (p_overflow) else $error("further error not flagged");

  property p_burst_qw;
    @(posedge aclk) disable iff (!aresetn)
    (ecc_uncorrectable && !status_q[`DRAMEL_ST_ERR] && !xfer_qword && !xfer_start) |=>
      fail_qw_q == $past(qw_cnt_q);
  endproperty
  a_burst_qw: assert property (p_burst_qw) else $error("burst quadword index wrong");

  property p_start_qw;
    @(posedge aclk) disable iff (!aresetn)
    (ecc_uncorrectable && xfer_start && !xfer_qword && !status_q[`DRAMEL_ST_ERR]) |=>
      fail_qw_q == 2'h0;
  endproperty
  a_start_qw: assert property (p_start_qw) else $error("first beat index not zero");

  property p_clear_flag;
    @(posedge aclk) disable iff (!aresetn)
    (clr[`DRAMEL_ST_ERR] && !ecc_uncorrectable) |=> !status_q[`DRAMEL_ST_ERR];
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("error flag not cleared");
endmodule

// File: dramel_dram_model.sv
// Purpose: passive model of the dram rows watching the refresh strobes
// Assumes: strobes are active low and change just after aclk
// Notes: records fall cycle and low width per row, and one refresh count from row 3 falls
`timescale 1ns/1ps
module dramel_dram_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // row strobes
  input wire logic [3:0] ras_n,
  // observations
  output logic [3:0][15:0] fall_q,
  output logic [3:0][3:0] len_q,
  output logic [15:0] nref_q
);
  logic [15:0] cyc_q;
  logic [3:0] prev_q;
  logic [3:0][3:0] run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_q <= 16'h0000;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end
  // strobes seen only at clock edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 4'hF;
      fall_q <= '0;
      len_q <= '0;
      run_q <= '0;
      nref_q <= 16'h0000;
    end else begin
      prev_q <= ras_n;
      for (int r = 0; r < 4; r++) begin
        if (prev_q[r] && !ras_n[r]) fall_q[r] <= cyc_q;
        run_q[r] <= ras_n[r] ? 4'h0 : run_q[r] + 4'h1;
        if (!prev_q[r] && ras_n[r]) len_q[r] <= run_q[r];
      end
      if (prev_q[3] && !ras_n[3]) nref_q <= nref_q + 16'h0001;
    end
  end
endmodule

// File: dram_error_log_and_timing_tb.sv
// Purpose: self-checking bench of the error log and timing block
// Assumes: one write and one read in flight, answers awaited in bounded loops
// Notes: refresh is watched through the dram model
`timescale 1ns/1ps
`include "dramel_consts.svh"
module dram_error_log_and_timing_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic xfer_start = 1'b0;
  logic xfer_qword = 1'b0;
  logic ecc_uncorrectable = 1'b0;
  logic [31:3] xfer_eff_addr = 29'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] dram_ras_n;
  logic [3:0][15:0] fall;
  logic [3:0][3:0] len;
  logic [15:0] nref;
  int errors = 0;
  int checked = 0;
  always #10 aclk = ~aclk;
  dramel_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .xfer_start(xfer_start), .xfer_qword(xfer_qword),
    .xfer_eff_addr(xfer_eff_addr), .ecc_uncorrectable(ecc_uncorrectable),
    .dram_ras_n(dram_ras_n), .irq(irq));
  dramel_dram_model dram (.aclk(aclk), .aresetn(aresetn), .ras_n(dram_ras_n),
    .fall_q(fall), .len_q(len), .nref_q(nref));
  task give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang(input string nm);
    errors++;
    $display("mismatch %s expected answer seen timeout", nm);
    give_verdict;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 64) hang("bvalid");
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 64) hang("rvalid");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d & m);
  endtask
  task automatic xfer(input logic single, input int k, input logic [31:3] a);
    for (int b = 0; b < 4; b++) begin
      @(posedge aclk);
      xfer_start <= !single && b == 0;
      xfer_qword <= single && b == 0;
      ecc_uncorrectable <= b == k;
      xfer_eff_addr <= a;
    end
    @(posedge aclk);
    xfer_start <= 1'b0;
    xfer_qword <= 1'b0;
    ecc_uncorrectable <= 1'b0;
  endtask
  task automatic wait_ref(input logic [15:0] n);
    int i;
    logic [15:0] s;
    s = nref;
    for (i = 0; i < 2000; i++) begin
      @(posedge aclk);
      if (nref - s >= n) break;
    end
    if (i == 2000) hang("refresh");
    repeat (6) @(posedge aclk);
  endtask
  task t_reset;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("timing", `DRAMEL_OFF_TIMING, 32'hFFFFFFFF, 32'h30DF3516);
    rdc("refresh count", `DRAMEL_OFF_TIMING, 32'h7FF00000, 32'h30D00000);
    rdc("fail addr", `DRAMEL_OFF_FAIL_ADDR, 32'hFFFFFFFF, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    $display("reset test done");
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    wr(`DRAMEL_OFF_FAIL_ADDR, 32'hFFFFFFFF, r);
    chk("ro bresp", 32'h0, {30'h0, r});
    rdc("ro fail addr", `DRAMEL_OFF_FAIL_ADDR, 32'hFFFFFFFF, 32'h0);
    rd(8'h40, d, r);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    wstrb <= 4'h1;
    w(`DRAMEL_OFF_TIMING, 32'h0);
    wstrb <= 4'hF;
    rdc("lane write", `DRAMEL_OFF_TIMING, 32'hFFFFFFFF, 32'h30DF3500);
    w(`DRAMEL_OFF_TIMING, 32'h30DF3516);
    $display("register access test done");
  endtask
  task t_single;
    xfer(1'b1, 0, 29'h0ABCDEF1);
    rdc("single addr", `DRAMEL_OFF_FAIL_ADDR, 32'hFFFFFFFF, 32'h55E6F788);
    rdc("flag", `DRAMEL_OFF_STATUS, 32'h3, 32'h1);
    xfer(1'b0, 2, 29'h15555555);
    rdc("kept addr", `DRAMEL_OFF_FAIL_ADDR, 32'hFFFFFFFF, 32'h55E6F788);
    rdc("further flag", `DRAMEL_OFF_STATUS, 32'h3, 32'h3);
    $display("single quadword test done");
  endtask
  task t_irq;
    w(`DRAMEL_OFF_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    w(`DRAMEL_OFF_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    w(`DRAMEL_OFF_MASK, 32'h1);
    w(`DRAMEL_OFF_STATUS, 32'h7);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("flag cleared", `DRAMEL_OFF_STATUS, 32'h3, 32'h0);
    $display("interrupt test done");
  endtask
  task t_burst;
    logic [31:3] a;
    for (int k = 0; k < 4; k++) begin
      a = 29'h00000003 + k;
      w(`DRAMEL_OFF_STATUS, 32'h3);
      xfer(1'b0, k, a);
      rdc("qword", `DRAMEL_OFF_FAIL_ADDR, 32'hFFFFFFFF, {a, k[1:0], 1'b0});
    end
    $display("burst quadword test done");
  endtask
  task t_refresh;
    logic [15:0] n0;
    logic [15:0] f0;
    w(`DRAMEL_OFF_TIMING, 32'h82853516);
    rdc("timing rw", `DRAMEL_OFF_TIMING, 32'hFFFFFFFF, 32'h02853516);
    wait_ref(16'h2);
    for (int r = 1; r < 4; r++) chk("stagger gap", 32'h2, {16'h0, fall[r] - fall[r-1]});
    for (int r = 0; r < 4; r++) chk("strobe low", 32'h3, {28'h0, len[r]});
    f0 = fall[0];
    wait_ref(16'h1);
    chk("interval", 32'h28, {16'h0, fall[0] - f0});
    rdc("refresh status", `DRAMEL_OFF_STATUS, 32'h4, 32'h4);
    w(`DRAMEL_OFF_TIMING, 32'h02813516);
    wait_ref(16'h2);
    for (int r = 1; r < 4; r++) chk("no stagger", 32'h0, {16'h0, fall[r] - fall[0]});
    w(`DRAMEL_OFF_TIMING, 32'h02803516);
    repeat (4) @(posedge aclk);
    n0 = nref;
    repeat (200) @(posedge aclk);
    chk("refresh off", {16'h0, n0}, {16'h0, nref});
    $display("refresh test done");
  endtask
  initial begin
    t_reset;
    t_regs;
    t_single;
    t_irq;
    t_burst;
    t_refresh;
    t_reset;
    give_verdict;
  end
endmodule
